// ===== shared/scc_pkg.sv
// Package for the strap configuration capture bank
package scc_pkg;
   // Register addresses (system address space)
   localparam logic [39:0] CFG_ADDR = 40'h00_1002_0008;
   localparam logic [39:0] MID_ADDR = 40'h00_1003_8000;
   // JTAG-side register select
   localparam logic JSEL_CFG = 1'h0;
   localparam logic JSEL_MID = 1'h1;
   // Field positions
   localparam int STRAP_W = 19;
   localparam int B_RSVD = 0;
   localparam int B_REFCLK = 1;
   localparam int B_TEST_LO = 2;
   localparam int B_TEST_HI = 4;
   localparam int B_BR0 = 5;
   localparam int B_BR1 = 6;
   localparam int B_PLL_LO = 7;
   localparam int B_PLL_HI = 11;
   localparam int B_SER0 = 12;
   localparam int B_SER0_GPIO = 13;
   localparam int B_SER1 = 14;
   localparam int B_SER1_GPIO = 15;
   localparam int B_CARD = 16;
   localparam int B_BOOT_LO = 17;
   localparam int B_BOOT_HI = 18;
   // Writable bit mask within the strap field
   localparam logic [18:0] WR_MASK = 19'h4_5000;
   // Boot source codes
   localparam logic [1:0] BOOT_ROM32 = 2'h0;
   localparam logic [1:0] BOOT_ROM8 = 2'h1;
   localparam logic [1:0] BOOT_EE_SMALL = 2'h2;
   localparam logic [1:0] BOOT_EE_LARGE = 2'h3;
   // Arbitrary identifier, not tied to any part
   localparam logic [63:0] MID_DEFAULT = 64'h0123_4567_89ab_cdef;
   // Decoded configuration outputs
   typedef struct packed {
      logic [1:0] boot_source;
      logic card_slot_enable;
      logic serial_one_gpio_alloc;
      logic serial_one_sync_select;
      logic serial_zero_gpio_alloc;
      logic serial_zero_sync_select;
      logic [4:0] pll_divide;
      logic bridge_one_clock_divider;
      logic bridge_zero_clock_divider;
      logic [2:0] factory_test;
      logic ref_clock_source_strap;
      logic strap_spare;
   } scc_cfg_t;
   // One register access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [63:0] wdata;
   } scc_acc_t;
endpackage

// ===== rtl/scc_bank.sv
// Strap configuration capture bank: configuration and identifier registers
// How it works
// - 64-bit read-only manufacturing identifier register
// - Bit 0 returns captured spare strap
// - Bit 1 reports reference clock source strap
// - Bits 2..4 report factory test straps
// - Bit 5 selects bridge zero divider
// - Bit 6 selects bridge one divider
// - Bits 11:7 report PLL divide strap
// - Bit 12 writable, serial zero mode
// - Bit 14 writable, serial one mode
// - Bit 13 reports serial zero pin allocation
// - Bit 15 reports serial one pin allocation
// - Bit 16 reports card slot mode strap
// - Boot field codes select boot source
// - Bit 17 read-only, bit 18 writable
// - Straps captured from pads at the first clock edge after reset
// - Reachable from system and JTAG ports
`timescale 1ns/1ps
`default_nettype none
module scc_bank #(
   parameter logic [63:0] MID_VALUE = scc_pkg::MID_DEFAULT
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Strap pads
   input wire logic [18:0] strap_pads_i,
   // System access
   input wire logic [39:0] sys_addr_i,
   input wire scc_pkg::scc_acc_t sys_acc_i,
   output logic [63:0] sys_rdata_o,
   output logic sys_rvalid_o,
   // JTAG access
   input wire logic jtag_sel_i,
   input wire scc_pkg::scc_acc_t jtag_acc_i,
   output logic [63:0] jtag_rdata_o,
   output logic jtag_rvalid_o,
   // Decoded configuration
   output scc_pkg::scc_cfg_t cfg_o,
   output logic smbus_zero_boot_o
);
   ////////////////////////////////////////////////////////////////////////
   // Local sizes
   localparam int CFG_W = scc_pkg::STRAP_W;
   localparam int WORD_W = 64;
   localparam int PAD_W = WORD_W - CFG_W;
   localparam logic [CFG_W-1:0] CFG_ZERO = '0;
   localparam logic [PAD_W-1:0] PAD_ZERO = '0;
   localparam logic [WORD_W-1:0] WORD_ZERO = '0;
   localparam logic [CFG_W-1:0] WR_BITS = (CFG_W'(1) << scc_pkg::B_SER0) |
      (CFG_W'(1) << scc_pkg::B_SER1) | (CFG_W'(1) << scc_pkg::B_BOOT_HI);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   if (CFG_W != scc_pkg::B_BOOT_HI + 1) begin : g_chk_width
      $error("Strap field width does not cover the field map");
   end
   if ($bits(scc_pkg::scc_cfg_t) != CFG_W) begin : g_chk_struct
      $error("Configuration struct does not match strap width");
   end
   if (scc_pkg::WR_MASK != WR_BITS) begin : g_chk_mask
      $error("Writable mask does not match the writable fields");
   end
   if (CFG_W > WORD_W) begin : g_chk_word
      $error("Strap field wider than the register word");
   end

   ////////////////////////////////////////////////////////////////////////
   // Strap capture
   logic capture_q;
   logic [CFG_W-1:0] cfg_q;
   logic [CFG_W-1:0] cfg_d;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         capture_q <= 1'b1;
      end else begin
         capture_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System address decode
   wire logic sys_cfg_hit;
   wire logic sys_mid_hit;
   wire logic sys_cfg_wr;

   assign sys_cfg_hit = (sys_addr_i == scc_pkg::CFG_ADDR);
   assign sys_mid_hit = (sys_addr_i == scc_pkg::MID_ADDR);
   assign sys_cfg_wr = sys_acc_i.wr & sys_cfg_hit;

   ////////////////////////////////////////////////////////////////////////
   // JTAG register select
   wire logic jtag_cfg_sel;
   wire logic jtag_mid_sel;
   wire logic jtag_cfg_wr;
   wire logic jtag_cfg_take;

   assign jtag_cfg_sel = (jtag_sel_i == scc_pkg::JSEL_CFG);
   assign jtag_mid_sel = (jtag_sel_i == scc_pkg::JSEL_MID);
   assign jtag_cfg_wr = jtag_acc_i.wr & jtag_cfg_sel;
   assign jtag_cfg_take = jtag_cfg_wr & ~sys_cfg_wr;

   ////////////////////////////////////////////////////////////////////////
   // Write merge
   wire logic [CFG_W-1:0] sys_wmask;
   wire logic [CFG_W-1:0] jtag_wmask;
   wire logic [CFG_W-1:0] wr_mask;
   wire logic [CFG_W-1:0] wr_data;
   wire logic [CFG_W-1:0] cfg_merged;

   assign sys_wmask = sys_cfg_wr ? scc_pkg::WR_MASK : CFG_ZERO;
   assign jtag_wmask = jtag_cfg_take ? scc_pkg::WR_MASK : CFG_ZERO;
   assign wr_mask = sys_wmask | jtag_wmask;
   assign wr_data = sys_cfg_wr ? sys_acc_i.wdata[CFG_W-1:0] : jtag_acc_i.wdata[CFG_W-1:0];
   assign cfg_merged = (cfg_q & ~wr_mask) | (wr_data & wr_mask);
   assign cfg_d = capture_q ? strap_pads_i : cfg_merged;

   ////////////////////////////////////////////////////////////////////////
   // Configuration register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_q <= CFG_ZERO;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Field split
   scc_pkg::scc_cfg_t cfg_next;
   assign cfg_next = '{
      boot_source: cfg_d[scc_pkg::B_BOOT_HI:scc_pkg::B_BOOT_LO],
      card_slot_enable: cfg_d[scc_pkg::B_CARD],
      serial_one_gpio_alloc: cfg_d[scc_pkg::B_SER1_GPIO],
      serial_one_sync_select: cfg_d[scc_pkg::B_SER1],
      serial_zero_gpio_alloc: cfg_d[scc_pkg::B_SER0_GPIO],
      serial_zero_sync_select: cfg_d[scc_pkg::B_SER0],
      pll_divide: cfg_d[scc_pkg::B_PLL_HI:scc_pkg::B_PLL_LO],
      bridge_one_clock_divider: cfg_d[scc_pkg::B_BR1],
      bridge_zero_clock_divider: cfg_d[scc_pkg::B_BR0],
      factory_test: cfg_d[scc_pkg::B_TEST_HI:scc_pkg::B_TEST_LO],
      ref_clock_source_strap: cfg_d[scc_pkg::B_REFCLK],
      strap_spare: cfg_d[scc_pkg::B_RSVD]
   };

   ////////////////////////////////////////////////////////////////////////
   // SMBus boot flag
   wire logic [1:0] boot_next;
   wire logic smbus_boot_d;

   assign boot_next = cfg_d[scc_pkg::B_BOOT_HI:scc_pkg::B_BOOT_LO];
   assign smbus_boot_d = (boot_next == scc_pkg::BOOT_EE_SMALL) | (boot_next == scc_pkg::BOOT_EE_LARGE);

   ////////////////////////////////////////////////////////////////////////
   // Read paths
   wire logic [WORD_W-1:0] cfg_word;
   wire logic [WORD_W-1:0] sys_rd;
   wire logic [WORD_W-1:0] sys_rd_d;
   wire logic [WORD_W-1:0] jtag_rd;
   wire logic [WORD_W-1:0] jtag_rd_d;

   assign cfg_word = {PAD_ZERO, cfg_q};
   assign sys_rd = sys_cfg_hit ? cfg_word : (sys_mid_hit ? MID_VALUE : WORD_ZERO);
   assign jtag_rd = jtag_mid_sel ? MID_VALUE : cfg_word;
   assign sys_rd_d = sys_acc_i.rd ? sys_rd : WORD_ZERO;
   assign jtag_rd_d = jtag_acc_i.rd ? jtag_rd : WORD_ZERO;

   ////////////////////////////////////////////////////////////////////////
   // System read port
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sys_rvalid_o <= 1'b0;
      end else begin
         sys_rvalid_o <= sys_acc_i.rd;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sys_rdata_o <= WORD_ZERO;
      end else begin
         sys_rdata_o <= sys_rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // JTAG read port
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         jtag_rvalid_o <= 1'b0;
      end else begin
         jtag_rvalid_o <= jtag_acc_i.rd;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         jtag_rdata_o <= WORD_ZERO;
      end else begin
         jtag_rdata_o <= jtag_rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration outputs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_o <= '0;
      end else begin
         cfg_o <= cfg_next;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         smbus_zero_boot_o <= 1'b0;
      end else begin
         smbus_zero_boot_o <= smbus_boot_d;
      end
   end
endmodule
`default_nettype wire

// ===== dv/scc_bank_checker.sv
// Assertion checker for the strap capture bank
`timescale 1ns/1ps
`default_nettype none
module scc_bank_checker #(parameter logic [63:0] MID_VALUE = scc_pkg::MID_DEFAULT) (
   input wire logic clk_i, rst_i, jtag_sel_i, sys_rvalid_o, jtag_rvalid_o, smbus_zero_boot_o,
   input wire logic [39:0] sys_addr_i,
   input wire scc_pkg::scc_acc_t sys_acc_i, jtag_acc_i,
   input wire logic [63:0] sys_rdata_o, jtag_rdata_o,
   input wire scc_pkg::scc_cfg_t cfg_o
);
   logic live_q;
   wire logic sc = sys_addr_i == scc_pkg::CFG_ADDR;
   wire logic jc = jtag_sel_i == scc_pkg::JSEL_CFG;
   wire logic sw = sys_acc_i.wr && sc;
   // Low during reset and capture edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         live_q <= 1'b0;
      end else begin
         live_q <= 1'b1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_sys_cfg_rd; sys_acc_i.rd && sc; endsequence
   a_sys_cfg_read: assert property (s_sys_cfg_rd |=> sys_rvalid_o && sys_rdata_o == {45'h0, $past(cfg_o)})
      else $error("sys cfg read wrong");
   a_sys_mid_read: assert property (sys_acc_i.rd && sys_addr_i == scc_pkg::MID_ADDR |=> sys_rdata_o == MID_VALUE)
      else $error("sys id read wrong");
   a_jtag_cfg_read: assert property (jtag_acc_i.rd && jc |=> jtag_rvalid_o && jtag_rdata_o == {45'h0, $past(cfg_o)})
      else $error("jtag cfg read wrong");
   a_jtag_mid_read: assert property (jtag_acc_i.rd && !jc |=> jtag_rdata_o == MID_VALUE)
      else $error("jtag id read wrong");
   a_ro_bits_hold: assert property (live_q |=> $stable(cfg_o & ~scc_pkg::WR_MASK))
      else $error("read-only bit moved");
   a_sys_write_takes: assert property (live_q && sw |=> (cfg_o & scc_pkg::WR_MASK) ==
      ($past(sys_acc_i.wdata[18:0]) & scc_pkg::WR_MASK)) else $error("sys write lost");
   a_jtag_write_takes: assert property (live_q && jtag_acc_i.wr && jc && !sw |=> (cfg_o & scc_pkg::WR_MASK) ==
      ($past(jtag_acc_i.wdata[18:0]) & scc_pkg::WR_MASK)) else $error("jtag write lost");
   a_smbus_flag: assert property (smbus_zero_boot_o == cfg_o.boot_source[1])
      else $error("smbus flag wrong");
endmodule
bind scc_bank scc_bank_checker #(.MID_VALUE(MID_VALUE)) scc_bank_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
   .jtag_sel_i(jtag_sel_i), .sys_rvalid_o(sys_rvalid_o), .jtag_rvalid_o(jtag_rvalid_o), .cfg_o(cfg_o),
   .smbus_zero_boot_o(smbus_zero_boot_o), .sys_addr_i(sys_addr_i), .sys_acc_i(sys_acc_i),
   .jtag_acc_i(jtag_acc_i), .sys_rdata_o(sys_rdata_o), .jtag_rdata_o(jtag_rdata_o));
`default_nettype wire

// ===== dv/tb_scc_bank.sv
// Self-checking bench for the strap capture bank
`timescale 1ns/1ps
`default_nettype none
module tb_scc_bank;
   logic clk_i = 1'h0, rst_i = 1'h1, jtag_sel_i = 1'h0, sys_rvalid_o, jtag_rvalid_o, smbus_zero_boot_o;
   logic [18:0] strap_pads_i = 19'h0, m;
   logic [39:0] sys_addr_i = 40'h0;
   logic [63:0] sys_rdata_o, jtag_rdata_o, r, d;
   scc_pkg::scc_acc_t sys_acc_i = '0, jtag_acc_i = '0;
   scc_pkg::scc_cfg_t cfg_o;
   integer seed = 36347, num_errors = 0, checks = 0, cyc = 0, i;
   scc_bank scc_bank_inst (.clk_i(clk_i), .rst_i(rst_i), .strap_pads_i(strap_pads_i), .sys_addr_i(sys_addr_i),
      .sys_acc_i(sys_acc_i), .sys_rdata_o(sys_rdata_o), .sys_rvalid_o(sys_rvalid_o), .jtag_sel_i(jtag_sel_i),
      .jtag_acc_i(jtag_acc_i), .jtag_rdata_o(jtag_rdata_o), .jtag_rvalid_o(jtag_rvalid_o), .cfg_o(cfg_o),
      .smbus_zero_boot_o(smbus_zero_boot_o));
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors = num_errors + 1;
         stop_test;
      end
   end
   task stop_test;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [63:0] g, input logic [63:0] e);
      checks = checks + 1;
      if (g !== e) begin
         num_errors = num_errors + 1;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // One access at a falling edge, result sampled a cycle later
   task acc(input logic j, input logic w, input logic [39:0] a, input logic [63:0] wd);
      jtag_sel_i = a == scc_pkg::MID_ADDR;
      sys_addr_i = a;
      if (j) jtag_acc_i = {!w, w, wd};
      else sys_acc_i = {!w, w, wd};
      @(negedge clk_i);
      r = j ? jtag_rdata_o : sys_rdata_o;
      sys_acc_i = '0;
      jtag_acc_i = '0;
      @(negedge clk_i);
   endtask
   // Expected configuration after a write
   function automatic logic [18:0] exp_cfg(input logic [18:0] old, input logic [63:0] wd);
      return (old & ~scc_pkg::WR_MASK) | (wd[18:0] & scc_pkg::WR_MASK);
   endfunction
   initial begin
      for (i = 0; i < 4; i = i + 1) begin
         strap_pads_i = {i[1:0], 17'($random(seed))};
         m = strap_pads_i;
         rst_i = 1;
         repeat (8) @(negedge clk_i);
         rst_i = 0;
         repeat (2) @(negedge clk_i);
         chk(64'(cfg_o), {45'h0, m});
         chk({63'h0, smbus_zero_boot_o}, {63'h0, m[18]});
         acc(i[0], 1'b0, scc_pkg::CFG_ADDR, 64'h0);
         chk(r, {45'h0, m});
         acc(!i[0], 1'b0, scc_pkg::MID_ADDR, 64'h0);
         chk(r, scc_pkg::MID_DEFAULT);
         $display("boot code %0d done", i);
      end
      acc(1'b0, 1'b0, 40'h00_1002_0010, 64'h0);
      chk(r, 64'h0);
      for (i = 0; i < 24; i = i + 1) begin
         d = i < 2 ? {64{i[0]}} : {$random(seed), $random(seed)};
         acc(i[1], 1'b1, scc_pkg::CFG_ADDR, d);
         m = exp_cfg(m, d);
         acc(!i[1], 1'b0, scc_pkg::CFG_ADDR, 64'h0);
         chk(r, {45'h0, m});
         acc(i[2], 1'b1, scc_pkg::MID_ADDR, d);
      end
      // Both sides write in one cycle: system side wins
      sys_addr_i = scc_pkg::CFG_ADDR;
      jtag_sel_i = scc_pkg::JSEL_CFG;
      sys_acc_i = {2'h1, 64'h0};
      jtag_acc_i = {2'h1, ~64'h0};
      @(negedge clk_i);
      sys_acc_i = '0;
      jtag_acc_i = '0;
      @(negedge clk_i);
      m = exp_cfg(m, 64'h0);
      acc(1'b1, 1'b0, scc_pkg::CFG_ADDR, 64'h0);
      chk(r, {45'h0, m});
      acc(1'b1, 1'b0, scc_pkg::MID_ADDR, 64'h0);
      chk(r, scc_pkg::MID_DEFAULT);
      $display("write tests done");
      stop_test;
   end
endmodule
`default_nettype wire
